// *** design/ipv_ctrl.v ***
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "ipv_defines.vh"
// How it works
// - Mode-A pin latched at reset release
// - Expanded mode: visibility bit enables read visibility
// - Other modes: visibility bit gates bus clock
// - Priority field writable only with I set
// - Codes 0000-0100 promote timer to async serial
// - Code 0101 reserved, acts as external pin
// - 0110 external pin, 0111 periodic tick
// - 1000-1111 promote captures, compares, shared channel
// - 25 sources onto 21 vectors, 15 maskable
// - Maskable need I clear; tick FFF0, pin FFF2
// - Nonmaskable FFF4 under X; traps FFF6, FFF8
// - Receive flag cleared by status-then-data read
// - Async serial sources share FFD6 with enables
// - Sync serial at FFD8 with own enable
// - Pulse edge FFDA, pulse overflow FFDC
// - Timer vectors FFDE up to FFEE
// - Watchdog FFFA, clock monitor FFFC, reset FFFE
// - Priority field resets to 0110
// - Unpromoted sources keep fixed default order
// - Promotion changes priority only, not vector/masks
module ipv_ctrl (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // CPU masks
  input wire cpu_i_mask,
  input wire cpu_x_mask,
  // Mode
  input wire mode_a_pin,
  input wire expanded_mode,
  output reg read_vis_en,
  output reg eclk_drive_en,
  // Nonmaskable sources
  input wire ext_reset_req,
  input wire clk_monitor_fail,
  input wire watchdog_fail,
  input wire nonmask_req_pin,
  input wire illegal_op_req,
  input wire soft_trap_instr,
  // Maskable sources
  input wire ext_req_pin,
  input wire periodic_tick_flag,
  input wire [7:0] timer_chan_flag,
  input wire timer_wrap_flag,
  input wire pulse_ovf_flag,
  input wire pulse_edge_flag,
  input wire sync_serial_flag,
  // Async serial unit
  input wire rx_char_done,
  input wire rx_overrun_flag,
  input wire tx_empty_flag,
  input wire tx_done_flag,
  input wire idle_flag,
  input wire sci_status_rd,
  input wire sci_data_rd,
  output wire rx_full_flag,
  // Vector to CPU
  output reg vec_req,
  output reg vec_nonmask,
  output reg [15:0] vec_addr
);

  reg [3:0] psel_reg;
  reg vis_reg;
  reg [`IPV_EN_WIDTH-1:0] en_reg;
  reg mode_a_latch_reg;
  reg mode_caught_reg;

  wire setup_ph;
  wire wr_acc;
  wire hit_ctl;
  wire hit_stat;
  wire hit_en;
  wire mapped;

  wire [14:0] mask_pend;
  wire [5:0] nmi_pend;
  wire async_pend;
  wire mask_found;
  wire [3:0] mask_idx;
  wire nmi_found;
  wire [2:0] nmi_idx;
  wire [3:0] promo_lane;
  wire promo_hit;
  wire [3:0] win_lane;
  wire [15:0] mask_vec;

  reg [15:0] nmi_vec;
  reg [31:0] rd_mux;
  reg [15:0] vec_next;

  // Maps a priority code onto its lane in the default order.
  function [3:0] ipv_promo_map;
    input [3:0] code;
    begin
      if (code <= `IPV_PSEL_LAST_LOW)
        ipv_promo_map = code + `IPV_LANE_TWRAP;
      else if (code == `IPV_PSEL_RSVD)
        ipv_promo_map = `IPV_LANE_EXT;
      else if (code == `IPV_PSEL_EXT)
        ipv_promo_map = `IPV_LANE_EXT;
      else
        ipv_promo_map = code - `IPV_PSEL_TMR_OFS;
    end
  endfunction

  // Bus decode: zero wait states, error on unmapped offsets.
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign hit_ctl = (paddr == `IPV_OFF_CTL);
  assign hit_stat = (paddr == `IPV_OFF_STAT);
  assign hit_en = (paddr == `IPV_OFF_EN);
  assign mapped = hit_ctl | hit_stat | hit_en;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Async serial subsystem folds its five causes into one lane.
  ipv_rx_flag u_rx_flag (
    .pclk(pclk),
    .presetn(presetn),
    .rx_done(rx_char_done),
    .status_rd(sci_status_rd),
    .data_rd(sci_data_rd),
    .rx_full_flag(rx_full_flag)
  );

  assign async_pend = ((rx_full_flag | rx_overrun_flag) & en_reg[`IPV_EN_RX_BIT]) |
                      (tx_empty_flag & en_reg[`IPV_EN_TXE_BIT]) |
                      (tx_done_flag & en_reg[`IPV_EN_TXC_BIT]) |
                      (idle_flag & en_reg[`IPV_EN_IDLE_BIT]);

  // Fifteen maskable lanes, lane 0 highest by default, all behind I.
  assign mask_pend[0] = ext_req_pin & ~cpu_i_mask;
  assign mask_pend[1] = periodic_tick_flag & en_reg[`IPV_EN_TICK_BIT] & ~cpu_i_mask;
  assign mask_pend[9:2] = timer_chan_flag &
                          en_reg[`IPV_EN_TMR_MSB:`IPV_EN_TMR_LSB] &
                          {8{~cpu_i_mask}};
  assign mask_pend[10] = timer_wrap_flag & en_reg[`IPV_EN_TWRAP_BIT] & ~cpu_i_mask;
  assign mask_pend[11] = pulse_ovf_flag & en_reg[`IPV_EN_POVF_BIT] & ~cpu_i_mask;
  assign mask_pend[12] = pulse_edge_flag & en_reg[`IPV_EN_PEDGE_BIT] & ~cpu_i_mask;
  assign mask_pend[13] = sync_serial_flag & en_reg[`IPV_EN_SPI_BIT] & ~cpu_i_mask;
  assign mask_pend[14] = async_pend & ~cpu_i_mask;

  // Six nonmaskable lanes in hardware priority order.
  assign nmi_pend[0] = ext_reset_req;
  assign nmi_pend[1] = clk_monitor_fail & en_reg[`IPV_EN_CME_BIT];
  assign nmi_pend[2] = watchdog_fail & ~en_reg[`IPV_EN_WDIS_BIT];
  assign nmi_pend[3] = nonmask_req_pin & ~cpu_x_mask;
  assign nmi_pend[4] = illegal_op_req;
  assign nmi_pend[5] = soft_trap_instr;

  ipv_first_set #(
    .N(15),
    .W(4)
  ) u_mask_enc (
    .req(mask_pend),
    .found(mask_found),
    .idx(mask_idx)
  );

  ipv_first_set #(
    .N(6),
    .W(3)
  ) u_nmi_enc (
    .req(nmi_pend),
    .found(nmi_found),
    .idx(nmi_idx)
  );

  // The promoted lane jumps the queue only when it is itself pending.
  assign promo_lane = ipv_promo_map(psel_reg);
  assign promo_hit = mask_pend[promo_lane];
  assign win_lane = promo_hit ? promo_lane : mask_idx;

  // Maskable vectors step down by two from the external pin lane.
  assign mask_vec = `IPV_VEC_MASK_TOP - {11'h000, win_lane, 1'b0};

  always @*
  begin
    nmi_vec = `IPV_VEC_RESET;
    case (nmi_idx)
      3'h0: nmi_vec = `IPV_VEC_RESET;
      3'h1: nmi_vec = `IPV_VEC_CLKMON;
      3'h2: nmi_vec = `IPV_VEC_WDOG;
      3'h3: nmi_vec = `IPV_VEC_NMI;
      3'h4: nmi_vec = `IPV_VEC_ILLEGAL;
      3'h5: nmi_vec = `IPV_VEC_TRAP;
      default: nmi_vec = `IPV_VEC_RESET;
    endcase
  end

  // Nonmaskable sources always outrank the maskable group.
  always @*
  begin
    if (nmi_found)
      vec_next = nmi_vec;
    else if (mask_found)
      vec_next = mask_vec;
    else
      vec_next = `IPV_VEC_IDLE;
  end

  // Request follows the pending sources, so it holds while they stay set.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vec_req <= 1'b0;
      vec_nonmask <= 1'b0;
      vec_addr <= `IPV_VEC_IDLE;
    end
    else
    begin
      vec_req <= nmi_found | mask_found;
      vec_nonmask <= nmi_found;
      vec_addr <= vec_next;
    end
  end

  // Mode-A level is caught on the first edge after reset release.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_a_latch_reg <= 1'b0;
      mode_caught_reg <= 1'b0;
    end
    else if (!mode_caught_reg)
    begin
      mode_a_latch_reg <= mode_a_pin;
      mode_caught_reg <= 1'b1;
    end
  end

  // Software-written control state.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      psel_reg <= `IPV_PSEL_RST;
      vis_reg <= `IPV_VIS_RST;
      en_reg <= `IPV_EN_RST;
    end
    else if (wr_acc)
    begin
      if (hit_ctl)
      begin
        vis_reg <= pwdata[`IPV_CTL_VIS_BIT];
        if (cpu_i_mask)
          psel_reg <= pwdata[`IPV_CTL_PSEL_MSB:`IPV_CTL_PSEL_LSB];
      end
      else if (hit_en)
        en_reg <= pwdata[`IPV_EN_WIDTH-1:0];
    end
  end

  // Visibility bit meaning depends on the operating mode.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      read_vis_en <= 1'b0;
      eclk_drive_en <= 1'b0;
    end
    else
    begin
      read_vis_en <= expanded_mode & vis_reg;
      eclk_drive_en <= ~expanded_mode & ~vis_reg;
    end
  end

  // Read data is captured in the setup phase for the zero-wait access.
  always @*
  begin
    rd_mux = 32'h00000000;
    if (hit_ctl)
    begin
      rd_mux[`IPV_CTL_PSEL_MSB:`IPV_CTL_PSEL_LSB] = psel_reg;
      rd_mux[`IPV_CTL_VIS_BIT] = vis_reg;
      rd_mux[`IPV_CTL_MDA_BIT] = mode_a_latch_reg;
    end
    else if (hit_stat)
    begin
      rd_mux[15:0] = vec_addr;
      rd_mux[`IPV_STAT_REQ_BIT] = vec_req;
      rd_mux[`IPV_STAT_RXF_BIT] = rx_full_flag;
    end
    else if (hit_en)
      rd_mux[`IPV_EN_WIDTH-1:0] = en_reg;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup_ph)
      prdata <= rd_mux;
  end

endmodule

// *** design/ipv_defines.vh ***
`ifndef IPV_DEFINES_VH
`define IPV_DEFINES_VH

// APB register byte offsets.
`define IPV_OFF_CTL 12'h000
`define IPV_OFF_STAT 12'h004
`define IPV_OFF_EN 12'h008

// Priority and miscellaneous control fields.
`define IPV_CTL_PSEL_LSB 0
`define IPV_CTL_PSEL_MSB 3
`define IPV_CTL_VIS_BIT 4
`define IPV_CTL_MDA_BIT 5
`define IPV_PSEL_RST 4'h6
`define IPV_VIS_RST 1'b0

// Local enable register fields.
`define IPV_EN_RX_BIT 0
`define IPV_EN_TXE_BIT 1
`define IPV_EN_TXC_BIT 2
`define IPV_EN_IDLE_BIT 3
`define IPV_EN_SPI_BIT 4
`define IPV_EN_PEDGE_BIT 5
`define IPV_EN_POVF_BIT 6
`define IPV_EN_TWRAP_BIT 7
`define IPV_EN_TICK_BIT 8
`define IPV_EN_TMR_LSB 9
`define IPV_EN_TMR_MSB 16
`define IPV_EN_WDIS_BIT 17
`define IPV_EN_CME_BIT 18
`define IPV_EN_WIDTH 19
`define IPV_EN_RST 19'h00000

// Status register fields.
`define IPV_STAT_REQ_BIT 16
`define IPV_STAT_RXF_BIT 17

// Maskable lanes in fixed default order.
`define IPV_LANE_EXT 4'h0
`define IPV_LANE_TICK 4'h1
`define IPV_LANE_TMR_LO 4'h2
`define IPV_LANE_TWRAP 4'hA
`define IPV_PSEL_LAST_LOW 4'h4
`define IPV_PSEL_RSVD 4'h5
`define IPV_PSEL_EXT 4'h6
`define IPV_PSEL_TMR_OFS 4'h6

// Vector addresses.
`define IPV_VEC_MASK_TOP 16'hFFF2
`define IPV_VEC_RESET 16'hFFFE
`define IPV_VEC_CLKMON 16'hFFFC
`define IPV_VEC_WDOG 16'hFFFA
`define IPV_VEC_NMI 16'hFFF4
`define IPV_VEC_ILLEGAL 16'hFFF8
`define IPV_VEC_TRAP 16'hFFF6
`define IPV_VEC_IDLE 16'hFFFE

`endif

// *** design/ipv_first_set.v ***
`timescale 1ns/100ps
// Lowest-numbered set request wins.
module ipv_first_set #(
  parameter N = 15,
  parameter W = 4
) (
  // Requests
  input wire [N-1:0] req,
  // Result
  output reg found,
  output reg [W-1:0] idx
);

  integer i;

  always @*
  begin
    found = 1'b0;
    idx = {W{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1)
    begin
      if (req[i])
      begin
        found = 1'b1;
        idx = i[W-1:0];
      end
    end
  end

endmodule

// *** design/ipv_rx_flag.v ***
`timescale 1ns/100ps
`include "ipv_defines.vh"
// Receive-full flag with status-then-data read clearing.
module ipv_rx_flag (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Events
  input wire rx_done,
  input wire status_rd,
  input wire data_rd,
  // Flag
  output wire rx_full_flag
);

  reg flag_reg;
  reg armed_reg;
  wire flag_next;

  // A new character arriving in the clearing cycle keeps the flag set.
  assign flag_next = rx_done | (flag_reg & ~(armed_reg & data_rd));
  assign rx_full_flag = flag_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_reg <= 1'b0;
      armed_reg <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
      if (status_rd & flag_reg)
        armed_reg <= 1'b1;
      else if (data_rd | rx_done)
        armed_reg <= 1'b0;
    end
  end

endmodule

// *** verif/ipv_cpu_model.sv ***
`timescale 1ns/100ps
module ipv_cpu_model (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Vector from the controller
  input wire vec_req,
  input wire [15:0] vec_addr,
  // Observed fetches
  output reg [15:0] fetch_addr,
  output reg [7:0] fetch_cnt
);
  reg req_q;

  // The core starts a vector fetch only on a fresh request.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      req_q <= 1'b0;
      fetch_addr <= 16'hFFFE;
      fetch_cnt <= 8'h00;
    end
    else
    begin
      req_q <= vec_req;
      if (vec_req && !req_q)
      begin
        fetch_addr <= vec_addr;
        fetch_cnt <= fetch_cnt + 8'h01;
      end
    end
endmodule

// *** verif/ipv_ctrl_chk.sv ***
`timescale 1ns/100ps
module ipv_ctrl_chk (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pslverr,
  input wire [31:0] prdata,
  // Masks and mode
  input wire cpu_i_mask,
  input wire mode_a_pin,
  input wire expanded_mode,
  input wire read_vis_en,
  input wire eclk_drive_en,
  // Sources
  input wire ext_reset_req,
  input wire clk_monitor_fail,
  input wire watchdog_fail,
  input wire nonmask_req_pin,
  input wire illegal_op_req,
  input wire soft_trap_instr,
  input wire ext_req_pin,
  input wire rx_char_done,
  // Outputs
  input wire rx_full_flag,
  input wire vec_req,
  input wire vec_nonmask,
  input wire [15:0] vec_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg seen;
  reg mda_q;
  reg [3:0] code_m;
  wire hi5 = ext_reset_req | clk_monitor_fail | watchdog_fail | nonmask_req_pin | illegal_op_req;
  wire rd_ctl = psel && !penable && !pwrite && paddr == 12'h000;

  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      seen <= 1'b0;
      mda_q <= 1'b0;
      code_m <= 4'h6;
    end
    else
    begin
      seen <= 1'b1;
      if (!seen)
        mda_q <= mode_a_pin;
      if (psel && penable && pwrite && paddr == 12'h000 && cpu_i_mask)
        code_m <= pwdata[3:0];
    end

  a_ctl_readback: assert property (rd_ctl && seen |=>
    prdata[3:0] == code_m && prdata[5] == mda_q)
    else $error("control readback wrong");
  a_vis_mode: assert property (read_vis_en || eclk_drive_en |-> read_vis_en == $past(expanded_mode))
    else $error("visibility output in wrong mode");
  a_imask_block: assert property (cpu_i_mask && !hi5 && !soft_trap_instr |=> !vec_req)
    else $error("maskable request passed mask");
  a_ext_served: assert property (ext_req_pin && !cpu_i_mask |=> vec_req)
    else $error("pending request not presented");
  a_reset_vec: assert property (ext_reset_req |=> vec_nonmask && vec_addr == 16'hFFFE)
    else $error("reset vector wrong");
  a_trap_vec: assert property (soft_trap_instr && !hi5 |=>
    vec_nonmask && vec_addr == 16'hFFF6)
    else $error("trap vector wrong");
  a_mask_range: assert property (vec_req && !vec_nonmask |->
    vec_addr >= 16'hFFD6 && vec_addr <= 16'hFFF2 && !vec_addr[0])
    else $error("maskable vector out of range");
  a_rx_set: assert property (rx_char_done |=> rx_full_flag)
    else $error("receive flag not set");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h008 |-> pslverr)
    else $error("unmapped access not refused");
  c_mask_win: cover property (vec_req && !vec_nonmask);
  c_nonmask: cover property (vec_nonmask);
  c_rx_full: cover property (rx_full_flag);
endmodule

bind ipv_ctrl ipv_ctrl_chk chk_i (.*);

// *** verif/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, im, xm, mode_a_latch, expm, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [17:0] s;
  logic [5:0] nm;
  logic [2:0] rxs;
  logic [18:0] en;
  logic [3:0] code;
  wire pready, pslverr, read_vis_en, eclk_drive_en, rx_full_flag, vec_req, vec_nonmask;
  wire [31:0] prdata;
  wire [15:0] vec_addr, fetch_addr;
  wire [7:0] fetch_cnt;
  int seed = 63431;
  int err_count = 0;
  int checks_done = 0;
  int n;

  ipv_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .cpu_i_mask(im), .cpu_x_mask(xm), .mode_a_pin(mode_a_latch), .expanded_mode(expm),
    .read_vis_en(read_vis_en), .eclk_drive_en(eclk_drive_en), .ext_reset_req(nm[0]),
    .clk_monitor_fail(nm[1]), .watchdog_fail(nm[2]), .nonmask_req_pin(nm[3]),
    .illegal_op_req(nm[4]), .soft_trap_instr(nm[5]), .ext_req_pin(s[0]),
    .periodic_tick_flag(s[1]), .timer_chan_flag(s[9:2]), .timer_wrap_flag(s[10]),
    .pulse_ovf_flag(s[11]), .pulse_edge_flag(s[12]), .sync_serial_flag(s[13]),
    .rx_char_done(rxs[0]), .rx_overrun_flag(s[14]), .tx_empty_flag(s[15]),
    .tx_done_flag(s[16]), .idle_flag(s[17]), .sci_status_rd(rxs[1]), .sci_data_rd(rxs[2]),
    .rx_full_flag(rx_full_flag), .vec_req(vec_req), .vec_nonmask(vec_nonmask),
    .vec_addr(vec_addr));
  ipv_cpu_model cpu (.pclk(pclk), .presetn(presetn), .vec_req(vec_req), .vec_addr(vec_addr),
    .fetch_addr(fetch_addr), .fetch_cnt(fetch_cnt));

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task print_verdict;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string nm_s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm_s, e, g);
      err_count++;
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_count++;
      print_verdict;
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task st(input int c);
    repeat (c) @(posedge pclk);
    @(negedge pclk);
  endtask

  task rxp(input logic [2:0] v);
    @(posedge pclk);
    rxs <= v;
    @(posedge pclk);
    rxs <= 3'h0;
  endtask

  // Winner among the pending sources: {nonmaskable, request, vector}.
  function automatic logic [17:0] expv();
    logic [14:0] m;
    logic [5:0] k;
    logic [17:0] r;
    int p;
    logic [15:0] nv [6] = '{16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFF4, 16'hFFF8, 16'hFFF6};
    m = {|(s[17:14] & en[3:0]), s[13] & en[4], s[12] & en[5], s[11] & en[6], s[10] & en[7],
      s[9:2] & en[16:9], s[1] & en[8], s[0]};
    if (im)
      m = 15'h0;
    k = {nm[5], nm[4], nm[3] & ~xm, nm[2] & ~en[17], nm[1] & en[18], nm[0]};
    p = code < 5 ? 10 + code : code < 7 ? 0 : code == 7 ? 1 : code - 6;
    r = 18'h0FFFE;
    for (int i = 14; i >= 0; i--)
      if (m[i])
        r = {2'b01, 16'hFFF2 - 16'(2 * i)};
    if (m[p])
      r = {2'b01, 16'hFFF2 - 16'(2 * p)};
    for (int i = 5; i >= 0; i--)
      if (k[i])
        r = {2'b11, nv[i]};
    return r;
  endfunction

  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, xm, expm} = 5'h00;
    {im, mode_a_latch} = 2'b11;
    {paddr, pwdata, s, nm, rxs, en} = 0;
    code = 4'h6;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk("ctl_reset", 32'h26, rd);
    apb(0, 12'h008, 0);
    chk("en_reset", 32'h0, rd);
    apb(0, 12'h00C, 0);
    chk("unmapped_err", 32'h1, se);
    im <= 1'b0;
    apb(1, 12'h000, 32'h13);
    apb(0, 12'h000, 0);
    chk("code_locked", 32'h36, rd);
    im <= 1'b1;
    apb(1, 12'h000, 32'h13);
    apb(0, 12'h000, 0);
    chk("code_write", 32'h33, rd);
    for (int v = 0; v < 2; v++)
    begin
      apb(1, 12'h000, {27'h0, v[0], 4'h6});
      for (int x = 0; x < 2; x++)
      begin
        @(posedge pclk);
        expm <= x[0];
        st(2);
        chk("vis", {x[0] & v[0], ~x[0] & ~v[0]}, {read_vis_en, eclk_drive_en});
      end
    end
    en = 19'h1;
    apb(1, 12'h008, 32'h1);
    im <= 1'b0;
    rxp(3'b001);
    st(2);
    chk("rx_set", 32'h5FFD6, {rx_full_flag, vec_nonmask, vec_req, vec_addr});
    apb(0, 12'h004, 0);
    chk("stat_read", 32'h3FFD6, rd);
    rxp(3'b100);
    st(2);
    chk("rx_hold", 32'h5FFD6, {rx_full_flag, vec_nonmask, vec_req, vec_addr});
    rxp(3'b010);
    rxp(3'b100);
    st(2);
    chk("rx_clear", 32'h0FFFE, {rx_full_flag, vec_nonmask, vec_req, vec_addr});
    for (int c = 0; c < 16; c++)
    begin
      @(posedge pclk);
      im <= 1'b1;
      code = c[3:0];
      apb(1, 12'h000, {28'h0, code});
      en = 19'($random(seed));
      apb(1, 12'h008, {13'h0, en});
      repeat (25)
      begin
        @(posedge pclk);
        s <= 18'($random(seed) & $random(seed) & $random(seed));
        nm <= 6'($random(seed) & $random(seed) & $random(seed) & $random(seed));
        {im, xm} <= 2'($random(seed) & $random(seed));
        st(1);
        chk("vector", expv(),
          {vec_nonmask, vec_req, vec_addr});
      end
    end
    chk("cpu_fetch", 32'h1, fetch_cnt != 8'h00);
    print_verdict;
  end
endmodule
